/* File: include/sprg_regs.svh */
// timing counts, command codes and field positions for the sector program controller
// assumes a 40 MHz mclk; every count is derived from the printed time and the period
`ifndef SPRG_REGS_SVH
`define SPRG_REGS_SVH

`define SPRG_CLK_NS 25
`define SPRG_T_WP_NS 90
`define SPRG_T_WPH_NS 100
`define SPRG_T_ACC_NS 150
`define SPRG_T_OEHP_NS 150
`define SPRG_T_BLC_US 150
`define SPRG_T_WC_MS 10

// least times round up
`define SPRG_WP_CYC ((`SPRG_T_WP_NS + `SPRG_CLK_NS - 1) / `SPRG_CLK_NS)
`define SPRG_WPH_CYC ((`SPRG_T_WPH_NS + `SPRG_CLK_NS - 1) / `SPRG_CLK_NS)
`define SPRG_ACC_CYC ((`SPRG_T_ACC_NS + `SPRG_CLK_NS - 1) / `SPRG_CLK_NS)
`define SPRG_OEHP_CYC ((`SPRG_T_OEHP_NS + `SPRG_CLK_NS - 1) / `SPRG_CLK_NS)
// load window rounds down; write cycle time rounds up
`define SPRG_BLC_CYC ((`SPRG_T_BLC_US * 1000) / `SPRG_CLK_NS)
`define SPRG_WC_CYC ((`SPRG_T_WC_MS * 1000000 + `SPRG_CLK_NS - 1) / `SPRG_CLK_NS)

`define SPRG_SECTOR_LSB 7
`define SPRG_LAST_BYTE 7'h7F
`define SPRG_TOGGLE_BIT 6

`define SPRG_UNLOCK_ADDR1 15'h5555
`define SPRG_UNLOCK_ADDR2 15'h2AAA
`define SPRG_UNLOCK_DATA1 8'hAA
`define SPRG_UNLOCK_DATA2 8'h55
`define SPRG_CODE_PROT_ON 8'hA0
`define SPRG_CODE_ERASE_PRE 8'h80
`define SPRG_CODE_PROT_OFF 8'h20
`define SPRG_CODE_ID_ENTER 8'h90
`define SPRG_CODE_ID_EXIT 8'hF0

`define SPRG_SEQ_PROT_ON_FIRST 4'h0
`define SPRG_SEQ_PROT_ON_LAST 4'h2
`define SPRG_SEQ_PROT_OFF_FIRST 4'h3
`define SPRG_SEQ_PROT_OFF_LAST 4'h8
`define SPRG_SEQ_ID_ENTER_FIRST 4'h9
`define SPRG_SEQ_ID_ENTER_LAST 4'hB
`define SPRG_SEQ_ID_EXIT_FIRST 4'hC
`define SPRG_SEQ_ID_EXIT_LAST 4'hE

`endif

/* File: include/sprg_pkg.sv */
// types shared by the sector program controller
// assumes nothing beyond a standard elaborator
package sprg_pkg;

    typedef enum logic [2:0] {
        OP_WRITE = 3'h0,
        OP_PROT_ON = 3'h1,
        OP_PROT_OFF = 3'h2,
        OP_ID = 3'h3,
        OP_READ = 3'h4
    } sprg_op_e;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SEQ = 7'h02,
        ST_LOAD = 7'h04,
        ST_BLC = 7'h08,
        ST_POLL = 7'h10,
        ST_READ = 7'h20,
        ST_DONE = 7'h40
    } sprg_state_e;

    typedef enum logic [2:0] {
        PH_IDLE = 3'h1,
        PH_ACT = 3'h2,
        PH_REC = 3'h4
    } sprg_phase_e;

endpackage : sprg_pkg

/* File: rtl/sprg_buf2.sv */
// two-entry buffer with valid and ready on both sides
// assumes one clock; in_ready is low only when both entries hold data
`timescale 1ns/1ps
module sprg_buf2 #(
    parameter int WIDTH = 8
) (
    input logic mclk,
    input logic reset,
    input logic in_valid,
    output logic in_ready,
    input logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end
        else if (push)
            mem_reg[wr_ptr_reg] <= in_data;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : sprg_buf2

/* File: rtl/sprg_ctrl.sv */
// host-side controller for a 64K x 8 sector-programmed parallel flash
// assumes flash data inputs are synchronous to mclk and the pad resolves dq from flash_dq_oe_n
`timescale 1ns/1ps
`include "sprg_regs.svh"
module sprg_ctrl #(
    parameter int unsigned BLC_CYC = `SPRG_BLC_CYC,
    parameter int unsigned WC_CYC = `SPRG_WC_CYC
) (
    input logic mclk,
    input logic reset,
    input logic cmd_valid,
    output logic cmd_ready,
    input sprg_pkg::sprg_op_e cmd_op,
    input logic [15:0] cmd_addr,
    input logic wr_valid,
    output logic wr_ready,
    input logic [7:0] wr_data,
    output logic rd_valid,
    input logic rd_ready,
    output logic [7:0] rd_data,
    output logic busy,
    output logic done,
    output logic err,
    output logic [15:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe_n,
    input logic [7:0] flash_dq_in
);
    import sprg_pkg::*;

    localparam logic [2:0] WP_LAST = 3'(`SPRG_WP_CYC - 1);
    localparam logic [2:0] WPH_LAST = 3'(`SPRG_WPH_CYC - 1);
    localparam logic [2:0] ACC_LAST = 3'(`SPRG_ACC_CYC - 1);
    localparam logic [2:0] OEHP_LAST = 3'(`SPRG_OEHP_CYC - 1);
    localparam logic [19:0] BLC_LAST = 20'(BLC_CYC - 1);
    localparam logic [19:0] GAP_LIM = 20'(BLC_CYC / 2);
    localparam logic [19:0] WC_LIM = 20'(WC_CYC);

    sprg_state_e state_reg, state_next;
    sprg_phase_e ph_reg;
    sprg_op_e op_reg, op_next;
    logic [15:0] addr_reg, addr_next;
    logic [3:0] idx_reg, idx_next;
    logic exit_reg, exit_next;
    logic [6:0] byte_reg, byte_next;
    logic [19:0] tmr_reg, tmr_next;
    logic prev_reg, prev_next;
    logic prev_ok_reg, prev_ok_next;
    logic err_reg, err_next;
    logic rd_lo_reg, rd_lo_next;
    logic is_rd_reg;
    logic [2:0] cnt_reg;
    logic poll_bit_reg;
    logic [15:0] flash_addr_reg;
    logic [7:0] dq_out_reg;
    logic ce_n_reg, oe_n_reg, we_n_reg, dq_oe_n_reg;
    logic buf_in_ready;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // command table: {A14..A0, data}
    function automatic logic [22:0] seq_rom(input logic [3:0] idx);
        case (idx)
            4'h0, 4'h3, 4'h6, 4'h9, 4'hC: seq_rom = {`SPRG_UNLOCK_ADDR1, `SPRG_UNLOCK_DATA1};
            4'h1, 4'h4, 4'h7, 4'hA, 4'hD: seq_rom = {`SPRG_UNLOCK_ADDR2, `SPRG_UNLOCK_DATA2};
            4'h2: seq_rom = {`SPRG_UNLOCK_ADDR1, `SPRG_CODE_PROT_ON};
            4'h5: seq_rom = {`SPRG_UNLOCK_ADDR1, `SPRG_CODE_ERASE_PRE};
            4'h8: seq_rom = {`SPRG_UNLOCK_ADDR1, `SPRG_CODE_PROT_OFF};
            4'hB: seq_rom = {`SPRG_UNLOCK_ADDR1, `SPRG_CODE_ID_ENTER};
            default: seq_rom = {`SPRG_UNLOCK_ADDR1, `SPRG_CODE_ID_EXIT};
        endcase
    endfunction : seq_rom

    wire [22:0] rom_word = seq_rom(idx_reg);
    wire eng_idle = (ph_reg == PH_IDLE);
    wire gap_out = (tmr_reg >= GAP_LIM);
    wire poll_out = (tmr_reg >= WC_LIM);
    wire in_seq = (state_reg == ST_SEQ);
    wire in_load = (state_reg == ST_LOAD);
    wire in_poll = (state_reg == ST_POLL);
    wire in_read = (state_reg == ST_READ);
    wire [8:0] sector = addr_reg[15:`SPRG_SECTOR_LSB];
    // unlock writes carry the target's A15 so that bit never moves mid-operation
    wire [15:0] seq_addr = {addr_reg[15], rom_word[22:8]};
    wire [15:0] load_addr = {sector, byte_reg};
    wire [15:0] poll_addr = {sector, `SPRG_LAST_BYTE};
    wire [15:0] read_addr = (op_reg == OP_ID) ? {15'h0000, rd_lo_reg} : addr_reg;
    wire go_wr = eng_idle && (in_seq || (in_load && wr_valid && !gap_out));
    wire go_rd = eng_idle && ((in_poll && !poll_out) || in_read);
    wire [15:0] go_addr = in_seq ? seq_addr : in_load ? load_addr : in_poll ? poll_addr : read_addr;
    wire [7:0] go_data = in_seq ? rom_word[7:0] : wr_data;
    wire [2:0] act_last = is_rd_reg ? ACC_LAST : WP_LAST;
    wire [2:0] rec_last = is_rd_reg ? OEHP_LAST : WPH_LAST;
    // a read for the user holds its strobe until the buffer has room, so no byte is dropped
    wire act_end = (ph_reg == PH_ACT) && (cnt_reg == act_last) && (!is_rd_reg || !in_read || buf_in_ready);
    wire cyc_done = (ph_reg == PH_REC) && (cnt_reg == rec_last);
    wire buf_push = act_end && is_rd_reg && in_read;
    wire [3:0] seq_first = (cmd_op == OP_PROT_ON) ? `SPRG_SEQ_PROT_ON_FIRST :
                           (cmd_op == OP_PROT_OFF) ? `SPRG_SEQ_PROT_OFF_FIRST : `SPRG_SEQ_ID_ENTER_FIRST;
    wire [3:0] seq_last = exit_reg ? `SPRG_SEQ_ID_EXIT_LAST :
                          (op_reg == OP_PROT_ON) ? `SPRG_SEQ_PROT_ON_LAST :
                          (op_reg == OP_PROT_OFF) ? `SPRG_SEQ_PROT_OFF_LAST : `SPRG_SEQ_ID_ENTER_LAST;

    assign cmd_ready = (state_reg == ST_IDLE);
    assign wr_ready = in_load && eng_idle && !gap_out;
    assign busy = (state_reg != ST_IDLE);
    assign done = (state_reg == ST_DONE);
    assign err = err_reg;
    assign flash_addr = flash_addr_reg;
    assign flash_ce_n = ce_n_reg;
    assign flash_oe_n = oe_n_reg;
    assign flash_we_n = we_n_reg;
    assign flash_dq_out = dq_out_reg;
    assign flash_dq_oe_n = dq_oe_n_reg;

    // bus cycle engine: strobe low phase then recovery phase
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            ph_reg <= PH_IDLE;
            cnt_reg <= 3'h0;
            is_rd_reg <= 1'b0;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            dq_oe_n_reg <= 1'b1;
            flash_addr_reg <= 16'h0000;
            dq_out_reg <= 8'h00;
            poll_bit_reg <= 1'b0;
        end
        else
        begin
            case (ph_reg)
                PH_IDLE:
                begin
                    if (go_wr || go_rd)
                    begin
                        ph_reg <= PH_ACT;
                        cnt_reg <= 3'h0;
                        is_rd_reg <= go_rd;
                        flash_addr_reg <= go_addr;
                        dq_out_reg <= go_data;
                        ce_n_reg <= 1'b0;
                        oe_n_reg <= go_wr;
                        we_n_reg <= go_rd;
                        dq_oe_n_reg <= go_rd;
                    end
                end
                PH_ACT:
                begin
                    if (act_end)
                    begin
                        ph_reg <= PH_REC;
                        cnt_reg <= 3'h0;
                        ce_n_reg <= 1'b1;
                        oe_n_reg <= 1'b1;
                        we_n_reg <= 1'b1;
                        if (is_rd_reg)
                            poll_bit_reg <= flash_dq_in[`SPRG_TOGGLE_BIT];
                    end
                    else if (cnt_reg != act_last)
                        cnt_reg <= cnt_reg + 3'h1;
                end
                PH_REC:
                begin
                    if (cyc_done)
                    begin
                        ph_reg <= PH_IDLE;
                        dq_oe_n_reg <= 1'b1;
                    end
                    else
                        cnt_reg <= cnt_reg + 3'h1;
                end
                default: ph_reg <= PH_IDLE;
            endcase
        end
    end

    always_comb
    begin
        state_next = state_reg;
        op_next = op_reg;
        addr_next = addr_reg;
        idx_next = idx_reg;
        exit_next = exit_reg;
        byte_next = byte_reg;
        tmr_next = tmr_reg;
        prev_next = prev_reg;
        prev_ok_next = prev_ok_reg;
        err_next = err_reg;
        rd_lo_next = rd_lo_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    op_next = cmd_op;
                    addr_next = cmd_addr;
                    idx_next = seq_first;
                    err_next = 1'b0;
                    byte_next = 7'h00;
                    exit_next = 1'b0;
                    rd_lo_next = 1'b0;
                    tmr_next = 20'h00000;
                    state_next = (cmd_op == OP_WRITE) ? ST_LOAD : (cmd_op == OP_READ) ? ST_READ : ST_SEQ;
                end
            end
            ST_SEQ:
            begin
                if (cyc_done && idx_reg == seq_last)
                begin
                    tmr_next = 20'h00000;
                    // exit sequence done: device is back in normal mode
                    state_next = exit_reg ? ST_DONE : (op_reg == OP_ID) ? ST_READ : ST_LOAD;
                end
                else if (cyc_done)
                    idx_next = idx_reg + 4'h1;
            end
            ST_LOAD:
            begin
                if (go_wr)
                    tmr_next = 20'h00000;
                else if (eng_idle && !gap_out)
                    tmr_next = tmr_reg + 20'h00001;
                if (eng_idle && gap_out)
                begin
                    // a starved load is cut short; the rest of the sector reads back undefined
                    err_next = 1'b1;
                    tmr_next = 20'h00000;
                    state_next = ST_BLC;
                end
                else if (cyc_done && byte_reg == `SPRG_LAST_BYTE)
                begin
                    tmr_next = 20'h00000;
                    state_next = ST_BLC;
                end
                else if (cyc_done)
                    byte_next = byte_reg + 7'h01;
            end
            ST_BLC:
            begin
                // reading early would end the load; wait out the window so programming starts
                tmr_next = tmr_reg + 20'h00001;
                if (tmr_reg == BLC_LAST)
                begin
                    tmr_next = 20'h00000;
                    prev_ok_next = 1'b0;
                    state_next = ST_POLL;
                end
            end
            ST_POLL:
            begin
                if (!poll_out)
                    tmr_next = tmr_reg + 20'h00001;
                if (cyc_done)
                begin
                    prev_next = poll_bit_reg;
                    prev_ok_next = 1'b1;
                    // only two equal reads in a row mean done; first and last values say nothing
                    if (prev_ok_reg && poll_bit_reg == prev_reg)
                        state_next = ST_DONE;
                end
                else if (eng_idle && poll_out)
                begin
                    err_next = 1'b1;
                    state_next = ST_DONE;
                end
            end
            ST_READ:
            begin
                if (cyc_done && op_reg == OP_ID && !rd_lo_reg)
                    rd_lo_next = 1'b1;
                else if (cyc_done && op_reg == OP_ID)
                begin
                    idx_next = `SPRG_SEQ_ID_EXIT_FIRST;
                    exit_next = 1'b1;
                    state_next = ST_SEQ;
                end
                else if (cyc_done)
                    state_next = ST_DONE;
            end
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ST_IDLE;
            op_reg <= OP_WRITE;
            addr_reg <= 16'h0000;
            idx_reg <= 4'h0;
            exit_reg <= 1'b0;
            byte_reg <= 7'h00;
            tmr_reg <= 20'h00000;
            prev_reg <= 1'b0;
            prev_ok_reg <= 1'b0;
            err_reg <= 1'b0;
            rd_lo_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
            idx_reg <= idx_next;
            exit_reg <= exit_next;
            byte_reg <= byte_next;
            tmr_reg <= tmr_next;
            prev_reg <= prev_next;
            prev_ok_reg <= prev_ok_next;
            err_reg <= err_next;
            rd_lo_reg <= rd_lo_next;
        end
    end

    sprg_buf2 #(.WIDTH(8)) u_rd_buf (
        .mclk(mclk),
        .reset(reset),
        .in_valid(buf_push),
        .in_ready(buf_in_ready),
        .in_data(flash_dq_in),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    chk_load_gap: assert property (in_load && !eng_idle |-> tmr_reg <= GAP_LIM)
        else $error("load gap exceeded limit");
    chk_sector_steady: assert property ($fell(flash_we_n) && in_load |-> flash_addr[15:7] == addr_reg[15:7])
        else $error("sector bits moved during load");
    chk_prot_sector: assert property ($fell(flash_we_n) && (in_seq || in_load) && op_reg != OP_WRITE
        |-> flash_addr[15] == addr_reg[15])
        else $error("upper address moved during protected sequence");
    chk_full_sector: assert property ($rose(state_reg == ST_BLC) && !err_reg |-> $past(byte_reg) == 7'h7F)
        else $error("sector ended before 128 bytes");
    chk_cmd_pattern: assert property ($fell(flash_we_n) && in_seq
        |-> flash_addr[14:0] == rom_word[22:8] && flash_dq_out == rom_word[7:0] && !flash_dq_oe_n)
        else $error("command byte or address wrong");
    chk_poll_addr: assert property ($fell(flash_oe_n) && in_poll |-> flash_addr == poll_addr)
        else $error("polling address changed");
    chk_poll_pair: assert property (in_poll && cyc_done && !prev_ok_reg |=> state_reg == ST_POLL)
        else $error("poll ended on a single read");
    chk_we_width: assert property ($fell(flash_we_n) |-> (!flash_we_n && flash_oe_n) [*4] ##1 flash_we_n [*4])
        else $error("write strobe timing short");
    chk_id_exit: assert property (in_read && op_reg == OP_ID && rd_lo_reg && cyc_done
        |=> in_seq && idx_reg == 4'hC)
        else $error("id read not followed by exit");

    cov_sector_write: cover property (in_poll ##1 state_reg == ST_DONE && !err_reg);
    cov_id_read: cover property (in_read && op_reg == OP_ID && buf_push && rd_lo_reg);
    cov_read_stall: cover property (in_read && ph_reg == PH_ACT && !buf_in_ready);
    cov_gap_abort: cover property (in_load && eng_idle && gap_out);
endmodule : sprg_ctrl

/* File: tb/sprg_flash_model.sv */
// behavioural flash device on the far side of the sector program controller
// assumes strobes come from flops on mclk; reads answer at once from the array, the ID bytes or the program status
`timescale 1ns/1ps
`include "sprg_regs.svh"
module sprg_flash_model #(
    parameter int GAP_CYC = 14,
    parameter int PROG_CYC = 300,
    parameter logic [7:0] MAKER_ID = 8'hC3, // arbitrary value
    parameter logic [7:0] PART_ID = 8'h3C // arbitrary value
) (
    input logic mclk,
    input logic hang,
    input logic [15:0] flash_addr,
    input logic flash_ce_n,
    input logic flash_oe_n,
    input logic flash_we_n,
    input logic [7:0] flash_dq_out,
    input logic flash_dq_oe_n,
    output logic [7:0] flash_dq_in
);
    logic [7:0] mem [0:65535];
    logic [127:0] loaded = '0;
    logic [22:0] h1 = '0;
    logic [22:0] h2 = '0;
    logic we_q = 1'b1;
    logic oe_q = 1'b1;
    logic id_mode = 1'b0;
    logic prot = 1'b0;
    logic tog = 1'b0;
    logic [1:0] prot_next = 2'h0;
    logic [8:0] sector = '0;
    logic [7:0] last = 8'h00;
    logic [7:0] wdat = 8'h00;
    int gap = 0;
    int prog = 0;
    wire [22:0] cur = {flash_addr[14:0], flash_dq_out};
    wire unl = h2 == {`SPRG_UNLOCK_ADDR1, `SPRG_UNLOCK_DATA1} && h1 == {`SPRG_UNLOCK_ADDR2, `SPRG_UNLOCK_DATA2};
    wire third = unl && flash_addr[14:0] == `SPRG_UNLOCK_ADDR1;
    // every unlock byte is a command, including the second unlock pair of a longer sequence
    wire is_cmd = third || cur == {`SPRG_UNLOCK_ADDR1, `SPRG_UNLOCK_DATA1} || cur == {`SPRG_UNLOCK_ADDR2, `SPRG_UNLOCK_DATA2};
    wire wr_edge = we_q && !flash_we_n && !flash_ce_n && !flash_dq_oe_n;
    // a released bus shows the inverse of its last value, never a stale copy
    always_comb
        if (flash_ce_n || flash_oe_n)
            flash_dq_in = ~last;
        else if (prog > 0)
            flash_dq_in = {~wdat[7], tog, 6'h00};
        else if (id_mode && flash_addr[15:1] == 15'h0000)
            flash_dq_in = flash_addr[0] ? PART_ID : MAKER_ID;
        else
            flash_dq_in = mem[flash_addr];
    always @(posedge mclk)
    begin
        we_q <= flash_we_n;
        oe_q <= flash_oe_n;
        if (!flash_ce_n && !flash_oe_n)
            last <= flash_dq_in;
        if (oe_q && !flash_oe_n && !flash_ce_n && prog > 0)
            tog <= ~tog;
        if (prog > 0 && !hang)
            prog <= prog - 1;
        if (prog == 1 && !hang && prot_next[1])
        begin
            prot <= prot_next[0];
            prot_next <= 2'h0;
        end
        if (wr_edge)
        begin
            h1 <= cur;
            h2 <= h1;
            mem[flash_addr] <= flash_dq_out;
            if (third && flash_dq_out == `SPRG_CODE_ID_ENTER)
                id_mode <= 1'b1;
            if (third && flash_dq_out == `SPRG_CODE_ID_EXIT)
                id_mode <= 1'b0;
            if (third && flash_dq_out == `SPRG_CODE_PROT_ON)
                prot_next <= 2'h3;
            if (third && flash_dq_out == `SPRG_CODE_PROT_OFF)
                prot_next <= 2'h2;
            if (!is_cmd)
            begin
                loaded[flash_addr[6:0]] <= 1'b1;
                sector <= flash_addr[15:7];
                wdat <= flash_dq_out;
                gap <= GAP_CYC;
            end
        end
        else if (gap > 0)
        begin
            gap <= gap - 1;
            if (gap == 1)
            begin
                prog <= PROG_CYC;
                loaded <= '0;
                for (int i = 0; i < 128; i++)
                    if (!loaded[i])
                        mem[{sector, i[6:0]}] <= {1'b0, i[6:0]} ^ 8'h5A;
            end
        end
    end
endmodule : sprg_flash_model

/* File: tb/sprg_ctrl_tb.sv */
// self-checking bench for the sector program controller
// assumes the behavioural flash model of this folder on the far side
`timescale 1ns/1ps
module sprg_ctrl_tb;
    import sprg_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic wr_valid = 1'b0;
    logic rd_ready = 1'b0;
    logic hang = 1'b0;
    sprg_op_e cmd_op = OP_READ;
    logic [15:0] cmd_addr = 16'h0000;
    logic [7:0] wr_data = 8'h00;
    logic cmd_ready, wr_ready, rd_valid, busy, done, err;
    logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n;
    logic [7:0] rd_data, flash_dq_out, flash_dq_in;
    logic [15:0] flash_addr;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #12.5 mclk = ~mclk;
    sprg_ctrl #(.BLC_CYC(40), .WC_CYC(2000)) dut (.mclk, .reset, .cmd_valid, .cmd_ready, .cmd_op,
        .cmd_addr, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data, .busy, .done, .err,
        .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_out, .flash_dq_oe_n, .flash_dq_in);
    sprg_flash_model fm (.mclk, .hang, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n,
        .flash_dq_out, .flash_dq_oe_n, .flash_dq_in);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic issue(input sprg_op_e op, input logic [15:0] a);
        @(negedge mclk);
        cmd_op = op;
        cmd_addr = a;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1)
            @(negedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask : issue
    task automatic load(input int n, input logic [7:0] seed);
        for (int k = 0; k < n; k++)
        begin
            @(negedge mclk);
            wr_valid = 1'b1;
            wr_data = seed + k[7:0];
            while (wr_ready !== 1'b1)
                @(negedge mclk);
            @(negedge mclk);
            wr_valid = 1'b0;
        end
    endtask : load
    task automatic wait_done(input int lim);
        int n;
        n = 0;
        while (done !== 1'b1 && n < lim)
        begin
            @(negedge mclk);
            n++;
        end
        check("done", 16'(n < lim), 16'h0001);
        @(negedge mclk);
    endtask : wait_done
    task automatic pop(input logic [7:0] exp);
        check("rd_valid", 16'(rd_valid), 16'h0001);
        check("rd_data", 16'(rd_data), 16'(exp));
        rd_ready = 1'b1;
        @(negedge mclk);
        rd_ready = 1'b0;
        @(negedge mclk);
    endtask : pop
    task automatic read_back(input logic [15:0] a, input logic [7:0] exp);
        issue(OP_READ, a);
        wait_done(200);
        pop(exp);
    endtask : read_back
    task automatic t_write();
        issue(OP_WRITE, 16'h0900);
        load(128, 8'h30);
        wait_done(5000);
        check("err", 16'(err), 16'h0000);
        read_back(16'h0900, 8'h30);
        read_back(16'h097F, 8'hAF);
    endtask : t_write
    task automatic t_starve();
        issue(OP_WRITE, 16'h1080);
        load(5, 8'h01);
        wait_done(5000);
        check("err", 16'(err), 16'h0001);
        read_back(16'h1090, 8'h4A);
    endtask : t_starve
    task automatic t_prot();
        issue(OP_PROT_ON, 16'h1800);
        load(128, 8'h02);
        check("prot", 16'(fm.prot), 16'h0000);
        wait_done(5000);
        check("prot", 16'(fm.prot), 16'h0001);
        issue(OP_PROT_OFF, 16'h1880);
        load(128, 8'h03);
        wait_done(5000);
        check("prot", 16'(fm.prot), 16'h0000);
    endtask : t_prot
    task automatic t_id();
        issue(OP_ID, 16'h0000);
        wait_done(500);
        pop(fm.MAKER_ID);
        pop(fm.PART_ID);
        check("id_mode", 16'(fm.id_mode), 16'h0000);
        // fill the buffer, then make the read wait for room
        issue(OP_ID, 16'h0000);
        wait_done(500);
        issue(OP_READ, 16'h0905);
        repeat (60) @(negedge mclk);
        check("busy", 16'(busy), 16'h0001);
        pop(fm.MAKER_ID);
        pop(fm.PART_ID);
        wait_done(200);
        pop(8'h35);
    endtask : t_id
    task automatic t_hang();
        hang = 1'b1;
        issue(OP_WRITE, 16'h2000);
        load(128, 8'h04);
        wait_done(5000);
        check("err", 16'(err), 16'h0001);
        hang = 1'b0;
    endtask : t_hang
    initial
    begin
        #(25 * 60000);
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        check("cmd_ready", 16'(cmd_ready), 16'h0001);
        check("strobes", 16'({flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n}), 16'h000F);
        reset = 1'b0;
        t_write();
        t_starve();
        t_prot();
        t_id();
        t_hang();
        end_of_test();
    end
endmodule : sprg_ctrl_tb
